// *** src/urs_pkg.sv ***
// Register map, field positions and codes of the serial transceiver
// Function
// - Falling edge while idle starts tick counting
// - Ticks count down from 16, 15 or 14
// - Vote of samples at ticks 8, 7, 6
// - Start bit voted 1 abandons the frame
// - Filter setting picks rejected pulse width
// - Buffer write sets full, frame is shifted out
// - Transfer start clears full, pulses transmit request
// - Newer buffer write replaces unsent byte
// - Line idles high, low in infrared mode
// - Good frame loads buffer, sets full, requests
// - Parity mismatch sets parity flag, requests
// - Stop bit 0 sets framing flag, requests
// - Overrun keeps old byte, sets flag, requests
// - Frames during overrun dropped without request
// - Errors of dropped frames set no flags
// - Buffer read clears flags armed by status read
// - Buffer read at parity clear returns the byte
// - Busy clears on idle end, sets on restart
// - Tick is divisor plus one base periods
// - Bit length select encodes 16/16-17/15/15-16/17
package urs_pkg;
    localparam int unsigned ADDR_W      = 5;
    localparam logic [4:0]  OFS_CTRL1   = 5'h00;
    localparam logic [4:0]  OFS_CTRL2   = 5'h04;
    localparam logic [4:0]  OFS_DIVISOR = 5'h08;
    localparam logic [4:0]  OFS_STATUS  = 5'h0c;
    localparam logic [4:0]  OFS_TXBUF   = 5'h10;
    localparam logic [4:0]  OFS_RXBUF   = 5'h14;
    // Control register 1 fields
    localparam int unsigned CR1_TX_EN   = 0;
    localparam int unsigned CR1_RX_EN   = 1;
    localparam int unsigned CR1_PAR_EN  = 2;
    localparam int unsigned CR1_PAR_ODD = 3;
    localparam int unsigned CR1_STOP2   = 4;
    localparam int unsigned CR1_IR_SEL  = 5;
    localparam int unsigned CR1_BASE_LO = 6;
    // Control register 2 fields
    localparam int unsigned CR2_LEN_LO  = 0;
    localparam int unsigned CR2_FLT_LO  = 3;
    localparam int unsigned CR2_LOWPWR  = 5;
    // Status register fields, receive flags first
    localparam int unsigned ST_RX_FULL  = 0;
    localparam int unsigned ST_PARITY_ERROR_FLAG     = 1;
    localparam int unsigned ST_FRAMING_ERROR_FLAG     = 2;
    localparam int unsigned ST_OVR      = 3;
    localparam int unsigned ST_TX_BUSY  = 4;
    localparam int unsigned ST_TX_FULL  = 5;
    localparam logic [7:0]  CR1_RESET   = 8'h00;
    localparam logic [7:0]  CR2_RESET   = 8'h00;
    localparam logic [7:0]  DIV_RESET   = 8'h00;
    // Bit length select codes, tick count tops
    localparam logic [2:0]  LEN_16      = 3'h0;
    localparam logic [2:0]  LEN_16_17   = 3'h1;
    localparam logic [2:0]  LEN_15      = 3'h2;
    localparam logic [2:0]  LEN_15_16   = 3'h3;
    localparam logic [2:0]  LEN_17      = 3'h4;
    localparam logic [4:0]  SAMPLE_HI   = 5'h08;
    localparam logic [4:0]  SAMPLE_LO   = 5'h06;
    localparam logic [3:0]  IDX_LAST_D  = 4'h8;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {URS_FLT_OFF, URS_FLT_1, URS_FLT_2, URS_FLT_4}
        urs_filter_t;
endpackage

// *** src/urs_uart.sv ***
// Serial transceiver with AXI4-Lite register slave
module urs_uart #(
    parameter int unsigned DIV_W = 8
) (
    input  wire logic                       clk_in,           // 40 MHz
    input  wire logic                       reset_in,         // Async, high
    input  wire logic [urs_pkg::ADDR_W-1:0] s_axi_awaddr_in,  // Write addr
    input  wire logic                       s_axi_awvalid_in, // Addr valid
    output logic                            s_axi_awready_out,// Addr ready
    input  wire logic [31:0]                s_axi_wdata_in,   // Write data
    input  wire logic [3:0]                 s_axi_wstrb_in,   // Byte lanes
    input  wire logic                       s_axi_wvalid_in,  // Data valid
    output logic                            s_axi_wready_out, // Data ready
    output logic [1:0]                      s_axi_bresp_out,  // Write resp
    output logic                            s_axi_bvalid_out, // Resp valid
    input  wire logic                       s_axi_bready_in,  // Resp ready
    input  wire logic [urs_pkg::ADDR_W-1:0] s_axi_araddr_in,  // Read addr
    input  wire logic                       s_axi_arvalid_in, // Addr valid
    output logic                            s_axi_arready_out,// Addr ready
    output logic [31:0]                     s_axi_rdata_out,  // Read data
    output logic [1:0]                      s_axi_rresp_out,  // Read resp
    output logic                            s_axi_rvalid_out, // Data valid
    input  wire logic                       s_axi_rready_in,  // Data ready
    input  wire logic                       rx_line_in,       // Serial in
    output logic                            tx_line_out,      // Serial out
    output logic                            tx_irq_out,       // Tx pulse
    output logic                            rx_irq_out        // Rx pulse
);
    import urs_pkg::*;

    localparam int unsigned CNT_W = DIV_W + 3;

    if (DIV_W < 1 || DIV_W > 8) begin : g_bad_div
        $error("urs_uart: DIV_W must lie in 1..8");
    end

    function automatic logic [4:0] bit_top(input logic [2:0] sel,
                                           input logic [3:0] idx);
        logic odd;
        odd = idx[0];
        unique case (sel)
            LEN_16:    bit_top = 5'h0f;
            LEN_16_17: bit_top = odd ? 5'h10 : 5'h0f;
            LEN_15:    bit_top = 5'h0e;
            LEN_15_16: bit_top = odd ? 5'h0f : 5'h0e;
            LEN_17:    bit_top = 5'h10;
            default:   bit_top = 5'h0f;
        endcase
    endfunction

    // Register file
    logic [7:0]       ctrl1;
    logic [7:0]       ctrl2;
    logic [DIV_W-1:0] divisor;
    logic [3:0]       rx_flags;
    logic [3:0]       rx_armed;
    logic [7:0]       rx_data;
    logic             tx_full;
    logic             tx_busy;
    logic [7:0]       tx_hold;

    // Bus slave state
    logic             aw_held;
    logic             w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;

    wire tx_en    = ctrl1[CR1_TX_EN];
    wire rx_en    = ctrl1[CR1_RX_EN];
    wire par_en   = ctrl1[CR1_PAR_EN];
    wire par_odd  = ctrl1[CR1_PAR_ODD];
    wire stop2    = ctrl1[CR1_STOP2];
    wire ir_sel   = ctrl1[CR1_IR_SEL];
    wire [1:0] base_sel = ctrl1[CR1_BASE_LO +: 2];
    wire [2:0] len_sel  = ctrl2[CR2_LEN_LO +: 3];
    wire [1:0] flt_sel  = ctrl2[CR2_FLT_LO +: 2];
    wire low_power      = ctrl2[CR2_LOWPWR];

    // Bus decode
    wire aw_fire  = s_axi_awvalid_in & s_axi_awready_out;
    wire w_fire   = s_axi_wvalid_in & s_axi_wready_out;
    wire wr_do    = aw_held & w_held & ~s_axi_bvalid_out;
    wire wr_lane0 = wr_do & w_strb[0];
    wire ar_fire  = s_axi_arvalid_in & s_axi_arready_out;
    wire wr_map   = aw_addr == OFS_CTRL1 || aw_addr == OFS_CTRL2 ||
                    aw_addr == OFS_DIVISOR || aw_addr == OFS_STATUS ||
                    aw_addr == OFS_TXBUF || aw_addr == OFS_RXBUF;
    wire rd_map   = s_axi_araddr_in == OFS_CTRL1 ||
                    s_axi_araddr_in == OFS_CTRL2 ||
                    s_axi_araddr_in == OFS_DIVISOR ||
                    s_axi_araddr_in == OFS_STATUS ||
                    s_axi_araddr_in == OFS_TXBUF ||
                    s_axi_araddr_in == OFS_RXBUF;
    wire status_rd = ar_fire & (s_axi_araddr_in == OFS_STATUS);
    wire rxbuf_rd  = ar_fire & (s_axi_araddr_in == OFS_RXBUF);
    wire tx_wr     = wr_lane0 & (aw_addr == OFS_TXBUF) & tx_en;
    wire [7:0] status_val = {2'h0, tx_full, tx_busy, rx_flags};
    // Buffer read that clears a parity flag returns the byte anyway
    wire [7:0] rd_byte =
        (s_axi_araddr_in == OFS_CTRL1)   ? ctrl1 :
        (s_axi_araddr_in == OFS_CTRL2)   ? ctrl2 :
        (s_axi_araddr_in == OFS_DIVISOR) ? 8'(divisor) :
        (s_axi_araddr_in == OFS_STATUS)  ? status_val :
        (s_axi_araddr_in == OFS_RXBUF)   ? rx_data : 8'h00;

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out  <= 1'b1;
            aw_held           <= 1'b0;
            w_held            <= 1'b0;
            aw_addr           <= '0;
            w_data            <= 32'h0;
            w_strb            <= 4'h0;
        end else begin
            if (aw_fire) begin
                aw_held           <= 1'b1;
                aw_addr           <= s_axi_awaddr_in;
                s_axi_awready_out <= 1'b0;
            end
            if (w_fire) begin
                w_held           <= 1'b1;
                w_data           <= s_axi_wdata_in;
                w_strb           <= s_axi_wstrb_in;
                s_axi_wready_out <= 1'b0;
            end
            if (wr_do) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
            end
            if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_awready_out <= 1'b1;
                s_axi_wready_out  <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out  <= RESP_OKAY;
        end else if (wr_do) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out  <= wr_map ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rdata_out   <= 32'h0;
            s_axi_rresp_out   <= RESP_OKAY;
        end else if (ar_fire) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b1;
            s_axi_rdata_out   <= {24'h0, rd_byte};
            s_axi_rresp_out   <= rd_map ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out  <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            ctrl1   <= CR1_RESET;
            ctrl2   <= CR2_RESET;
            divisor <= DIV_RESET[DIV_W-1:0];
        end else if (wr_lane0) begin
            if (aw_addr == OFS_CTRL1)   ctrl1   <= w_data[7:0];
            if (aw_addr == OFS_CTRL2)   ctrl2   <= w_data[7:0];
            if (aw_addr == OFS_DIVISOR) divisor <= w_data[DIV_W-1:0];
        end
    end

    // Base clock prescaler and oversample tick
    logic [2:0]       pre_cnt;
    logic [DIV_W-1:0] div_cnt;
    logic             tick;
    wire [2:0] pre_top = 3'((4'h1 << base_sel) - 4'h1);
    wire base_en = (pre_cnt == pre_top);
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            pre_cnt <= 3'h0;
            div_cnt <= '0;
            tick    <= 1'b0;
        end else begin
            pre_cnt <= base_en ? 3'h0 : pre_cnt + 3'h1;
            tick    <= base_en && div_cnt == divisor;
            if (base_en) div_cnt <= (div_cnt == divisor) ? '0 : div_cnt + 1'b1;
        end
    end

    // Receive line: synchroniser, filter, edge detect
    logic rx_meta;
    logic rx_sync;
    logic rx_filt;
    logic rx_prev;
    logic [CNT_W-1:0] flt_cnt;
    wire [CNT_W-1:0] flt_unit  = CNT_W'(divisor) + CNT_W'(1);
    wire [CNT_W-1:0] flt_limit =
        (flt_sel == URS_FLT_1) ? flt_unit :
        (flt_sel == URS_FLT_2) ? CNT_W'(flt_unit << 1) :
                                 CNT_W'(flt_unit << 2);
    wire flt_pass = (flt_sel == URS_FLT_OFF) ||
                    (base_en && flt_cnt + CNT_W'(1) >= flt_limit);
    wire rx_fall  = rx_prev & ~rx_filt;
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
            rx_filt <= 1'b1;
            rx_prev <= 1'b1;
            flt_cnt <= '0;
        end else begin
            rx_meta <= rx_line_in;
            rx_sync <= rx_meta;
            rx_prev <= rx_filt;
            // Level must stay changed for the whole rejection time
            if (rx_sync == rx_filt) begin
                flt_cnt <= '0;
            end else if (flt_pass) begin
                rx_filt <= rx_sync;
                flt_cnt <= '0;
            end else if (base_en) begin
                flt_cnt <= flt_cnt + CNT_W'(1);
            end
        end
    end

    // Receiver
    logic       rx_active;
    logic [4:0] rx_cnt;
    logic [3:0] rx_idx;
    logic [2:0] rx_votes;
    logic [7:0] rx_shift;
    logic       rx_parity_error_flag_acc;
    logic       rx_framing_error_flag_acc;
    logic       rx_discard;
    wire maj = (rx_votes[0] & rx_votes[1]) | (rx_votes[0] & rx_votes[2]) |
               (rx_votes[1] & rx_votes[2]);
    wire rx_sample = tick & rx_active & rx_cnt <= SAMPLE_HI &
                     rx_cnt >= SAMPLE_LO;
    wire rx_end_bit = tick & rx_active & (rx_cnt == 5'h00);
    wire [3:0] rx_last = IDX_LAST_D + 4'h1 + {3'h0, par_en} + {3'h0, stop2};
    wire rx_start   = ~rx_active & rx_en & rx_fall;
    wire rx_abort   = rx_end_bit & (rx_idx == 4'h0) & maj;
    wire data_done  = rx_end_bit & (rx_idx == IDX_LAST_D);
    wire frame_done = rx_end_bit & (rx_idx == rx_last);
    wire is_par_bit = par_en & (rx_idx == IDX_LAST_D + 4'h1);
    wire framing_error_flag_now   = rx_framing_error_flag_acc | ~maj;
    wire rx_load    = frame_done & ~rx_discard;
    wire ovr_new    = data_done & rx_flags[ST_RX_FULL] &
                      ~rx_flags[ST_OVR];
    wire [3:0] rx_set = {ovr_new, rx_load & framing_error_flag_now,
                         rx_load & rx_parity_error_flag_acc, rx_load};

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            rx_active   <= 1'b0;
            rx_cnt      <= 5'h00;
            rx_idx      <= 4'h0;
            rx_votes    <= 3'h7;
            rx_shift    <= 8'h00;
            rx_parity_error_flag_acc <= 1'b0;
            rx_framing_error_flag_acc <= 1'b0;
            rx_discard  <= 1'b0;
        end else if (!rx_en || rx_abort || frame_done) begin
            rx_active <= 1'b0;
        end else if (rx_start) begin
            rx_active   <= 1'b1;
            rx_cnt      <= bit_top(len_sel, 4'h0);
            rx_idx      <= 4'h0;
            rx_parity_error_flag_acc <= 1'b0;
            rx_framing_error_flag_acc <= 1'b0;
        end else if (rx_end_bit) begin
            rx_cnt <= bit_top(len_sel, rx_idx + 4'h1);
            rx_idx <= rx_idx + 4'h1;
            if (rx_idx != 4'h0 && rx_idx <= IDX_LAST_D)
                rx_shift <= {maj, rx_shift[7:1]};
            if (data_done)
                rx_discard <= rx_flags[ST_RX_FULL] | rx_flags[ST_OVR];
            if (is_par_bit)
                rx_parity_error_flag_acc <= maj ^ (^rx_shift) ^ par_odd;
            else if (rx_idx > IDX_LAST_D)
                rx_framing_error_flag_acc <= framing_error_flag_now;
        end else if (tick && rx_active) begin
            rx_cnt <= rx_cnt - 5'h01;
            if (rx_sample) rx_votes <= {rx_votes[1:0], rx_filt};
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            rx_data    <= 8'h00;
            rx_irq_out <= 1'b0;
        end else begin
            if (rx_load) rx_data <= rx_shift;
            rx_irq_out <= rx_load | ovr_new;
        end
    end

    // Receive flags: set wins, clear only if armed by status read
    for (genvar i = 0; i < 4; i++) begin : g_flag
        always_ff @(posedge clk_in or posedge reset_in) begin
            if (reset_in) begin
                rx_flags[i] <= 1'b0;
                rx_armed[i] <= 1'b0;
            end else begin
                rx_flags[i] <= rx_set[i] |
                               (rx_flags[i] & ~(rxbuf_rd & rx_armed[i]));
                if (status_rd)
                    rx_armed[i] <= rx_flags[i];
                else if (rxbuf_rd)
                    rx_armed[i] <= 1'b0;
            end
        end
    end

    // Transmitter
    logic       tx_cnt_run;
    logic [4:0] tx_cnt;
    logic [3:0] tx_idx;
    logic [7:0] tx_data;
    wire tx_run = tx_en & ~low_power;
    wire [3:0] tx_last = IDX_LAST_D + 4'h1 + {3'h0, par_en} + {3'h0, stop2};
    wire tx_end  = tick & tx_busy & (tx_cnt == 5'h00) & (tx_idx == tx_last);
    wire tx_load = tx_run & tx_full & (~tx_busy | tx_end);
    wire tx_bit  =
        (tx_idx == 4'h0)       ? 1'b0 :
        (tx_idx <= IDX_LAST_D) ? tx_data[3'(tx_idx - 4'h1)] :
        (par_en && tx_idx == IDX_LAST_D + 4'h1) ? (^tx_data) ^ par_odd :
                                 1'b1;
    // Infrared sends a high pulse in the first three ticks of each 0
    wire ir_pulse = ~tx_bit & (tx_cnt + 5'h03 > bit_top(len_sel, tx_idx));
    wire next_tx_line = (!tx_run || !tx_busy) ? ~ir_sel :
                        ir_sel ? ir_pulse : tx_bit;

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            tx_full <= 1'b0;
            tx_hold <= 8'h00;
        end else begin
            if (tx_wr) tx_hold <= w_data[7:0];
            tx_full <= tx_wr | (tx_full & ~tx_load);
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            tx_busy    <= 1'b0;
            tx_cnt_run <= 1'b0;
            tx_cnt     <= 5'h00;
            tx_idx     <= 4'h0;
            tx_data    <= 8'h00;
        end else if (!tx_run) begin
            tx_busy <= 1'b0;
        end else if (tx_load) begin
            tx_busy <= 1'b1;
            tx_data <= tx_hold;
            tx_idx  <= 4'h0;
            tx_cnt  <= bit_top(len_sel, 4'h0);
        end else if (tx_end) begin
            tx_busy <= 1'b0;
        end else if (tick && tx_busy) begin
            if (tx_cnt == 5'h00) begin
                tx_idx <= tx_idx + 4'h1;
                tx_cnt <= bit_top(len_sel, tx_idx + 4'h1);
            end else begin
                tx_cnt <= tx_cnt - 5'h01;
            end
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            tx_line_out <= 1'b1;
            tx_irq_out  <= 1'b0;
        end else begin
            tx_line_out <= next_tx_line;
            tx_irq_out  <= tx_load;
        end
    end

    a_start_count: assert property (@(posedge clk_in) disable iff (reset_in)
        rx_start |=> rx_active && rx_cnt == bit_top($past(len_sel), 4'h0)
    ) else $error("start did not load the first bit length");
    a_start_abort: assert property (@(posedge clk_in) disable iff (reset_in)
        rx_abort |=> !rx_active && !rx_irq_out
    ) else $error("false start bit did not abandon frame");
    a_sample_window: assert property (@(posedge clk_in) disable iff (reset_in)
        rx_sample |-> rx_cnt inside {5'h06, 5'h07, 5'h08}
    ) else $error("sample outside ticks 8 to 6");
    a_rx_irq_pulse: assert property (@(posedge clk_in) disable iff (reset_in)
        rx_irq_out |=> !rx_irq_out
    ) else $error("receive request longer than one cycle");
    a_overrun_keep: assert property (@(posedge clk_in) disable iff (reset_in)
        ovr_new |=> rx_flags[ST_OVR] && rx_irq_out ##1 $stable(rx_data)
    ) else $error("overrun did not flag or changed the buffer");
    a_silent_drop: assert property (@(posedge clk_in) disable iff (reset_in)
        (frame_done && rx_discard) |=> !rx_irq_out && $stable(rx_data)
    ) else $error("discarded frame raised request");
    a_flag_hold: assert property (@(posedge clk_in) disable iff (reset_in)
        (rxbuf_rd && !rx_armed[ST_RX_FULL] && rx_flags[ST_RX_FULL])
        |=> rx_flags[ST_RX_FULL]
    ) else $error("unarmed full flag cleared");
    a_tx_start: assert property (@(posedge clk_in) disable iff (reset_in)
        (tx_load && !tx_wr) |=> !tx_full && tx_busy && tx_irq_out
    ) else $error("transfer start did not clear full");
    a_tx_idle: assert property (@(posedge clk_in) disable iff (reset_in)
        !tx_run |=> tx_line_out == !$past(ir_sel)
    ) else $error("disabled line not at idle level");
    a_busy_end: assert property (@(posedge clk_in) disable iff (reset_in)
        (tx_end && !tx_full) |=> !tx_busy
    ) else $error("busy did not clear at end");
endmodule

// *** bench/urs_peer.sv ***
// Serial peer model on both lines of the transceiver
module urs_peer #(parameter int BIT_NS = 400) (
    input  wire logic tx_in,  // Device tx line
    output logic      rx_out  // Device rx line
);
    timeunit 1ns;
    timeprecision 100ps;
    initial rx_out = 1'b1;
    // Line idles high between frames, never left floating
    task automatic send(input logic [7:0] d, input logic stop);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_out = f[i];
            #(BIT_NS);
        end
        rx_out = 1'b1;
        #(BIT_NS);
    endtask
    // Low pulse too short to survive the start vote
    // Waits past the abandoned start bit so the next fall is seen
    task automatic glitch();
        rx_out = 1'b0;
        #75;
        rx_out = 1'b1;
        #(2 * BIT_NS);
    endtask
    task automatic recv(output logic [7:0] d);
        @(negedge tx_in);
        #(BIT_NS * 3 / 2);
        for (int i = 0; i < 8; i++) begin
            d[i] = tx_in;
            #(BIT_NS);
        end
    endtask
endmodule

// *** bench/urs_uart_tb.sv ***
// Self-checking bench for the serial transceiver
module urs_uart_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import urs_pkg::*;
    logic clk_in = 1'b0, reset_in = 1'b1;
    logic [4:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, rx_line, tx_line;
    logic tx_irq, rx_irq;
    logic [1:0] bresp, rresp;
    logic [7:0] v;
    int n_fail = 0, check_count = 0, n_tx = 0, n_rx = 0;
    always #12.5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        n_tx += int'(tx_irq === 1'b1);
        n_rx += int'(rx_irq === 1'b1);
    end
    urs_uart dut (.clk_in(clk_in), .reset_in(reset_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(4'h1), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .rx_line_in(rx_line),
        .tx_line_out(tx_line), .tx_irq_out(tx_irq), .rx_irq_out(rx_irq));
    urs_peer peer (.tx_in(tx_line), .rx_out(rx_line));
    task automatic chk(string s, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr(logic [4:0] a, logic [7:0] d, logic [1:0] r);
        @(posedge clk_in);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk_in);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        bready <= 1'b0;
        chk("bresp", {30'h0, r}, {30'h0, bresp});
    endtask
    task automatic rd(logic [4:0] a, logic [7:0] e, logic [1:0] r);
        @(posedge clk_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk_in);
            if (arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        rready <= 1'b0;
        chk("rdata", {22'h0, r, e}, {22'h0, rresp, rdata[7:0]});
    endtask
    // Status, buffer, then status again must show all cleared
    task automatic rx_check(logic [7:0] st, logic [7:0] d);
        repeat (8) @(posedge clk_in);
        rd(OFS_STATUS, st, RESP_OKAY);
        rd(OFS_RXBUF, d, RESP_OKAY);
        rd(OFS_STATUS, 8'h00, RESP_OKAY);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_fail++;
        complete_run();
    end
    initial begin
        repeat (5) @(posedge clk_in);
        reset_in <= 1'b0;
        rd(OFS_CTRL1, 8'h00, RESP_OKAY);
        rd(5'h1c, 8'h00, RESP_SLVERR);
        wr(5'h18, 8'h01, RESP_SLVERR);
        chk("tx_line", 1, tx_line);
        $display("test reset done");
        wr(OFS_CTRL1, 8'h02, RESP_OKAY);
        peer.send(8'ha5, 1'b1);
        rx_check(8'h01, 8'ha5);
        peer.glitch();
        peer.send(8'h3c, 1'b1);
        rx_check(8'h01, 8'h3c);
        $display("test receive done");
        peer.send(8'h11, 1'b1);
        peer.send(8'h22, 1'b0);
        peer.send(8'h33, 1'b1);
        rx_check(8'h09, 8'h11);
        peer.send(8'h55, 1'b0);
        rx_check(8'h05, 8'h55);
        chk("rx_irq", 5, n_rx);
        $display("test errors done");
        wr(OFS_CTRL1, 8'h03, RESP_OKAY);
        chk("tx_line", 1, tx_line);
        fork
            wr(OFS_TXBUF, 8'h5a, RESP_OKAY);
            peer.recv(v);
        join
        chk("tx_data", 8'h5a, v);
        #800;
        rd(OFS_STATUS, 8'h00, RESP_OKAY);
        chk("tx_irq", 1, n_tx);
        wr(OFS_CTRL1, 8'h21, RESP_OKAY);
        repeat (2) @(posedge clk_in);
        chk("tx_line_ir", 0, tx_line);
        $display("test transmit done");
        complete_run();
    end
endmodule
